// file: ccu_unit.sv
// Purpose: One capture/compare unit: control, value and flag registers, capture and compare.
// Assumes: Timer count and timer tick come from the host end on the same clock.
// Notes: Pin inputs pass two flip-flops; pin outputs and enables come from flip-flops.
`timescale 1ns/1ns
`include "ccu_defines.svh"

// Function
// - Prescaler cleared when off or not capturing.
// - Any reset clears the prescaler counter.
// - Changing capture prescale keeps counter; false flag possible.
// - Software zeroes control before new prescale.
// - Instruction-clocked timer halts in sleep, then resumes.
// - External-clocked timer keeps capture working in sleep.
// - Compare value checked continuously against timer.
// - Match performs toggle, set, clear, trigger, flag.
// - Every compare mode sets flag on match.
// - Special event trigger clears the whole timer.
// - Trigger timer clear never sets overflow flag.
// - Unit two trigger also starts a conversion.
// - Writing zero to control forces output low.
// - Software makes pin an output for compare.
// - Software runs timer synchronized, not asynchronous.
// - Timer never clocked straight from system oscillator.
// - Mode 1010 flags only, pin left alone.
// - Unit two pin select picks package pin.
// - Capture on fall, rise, 4th, 16th rise.
// - Capture sets flag; newer capture overwrites value.
// - Trigger fires at once; clear at tick.
module ccu_unit
	import ccu_pkg::*;
#(
	parameter int UNIT_ID = 1
) (
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	ccu_link_if.dev LINK,
	input wire logic PIN_A_I,
	input wire logic PIN_B_I,
	input wire logic DIR_OUT_I,
	output logic PIN_A_O,
	output logic PIN_A_OE_O,
	output logic PIN_B_O,
	output logic PIN_B_OE_O,
	output logic IRQ_FLAG_O,
	output logic IRQ_O,
	output logic ADC_START_O
);

	if (UNIT_ID < 1 || UNIT_ID > 2) begin : g_bad_unit
		$error("ccu_unit: UNIT_ID must be 1 or 2");
	end

	localparam logic IS_UNIT_TWO = (UNIT_ID == 2);

	function automatic logic is_capture(input logic [3:0] m);
		is_capture = (m == CCU_CAP_FALL) || (m == CCU_CAP_RISE) ||
			(m == CCU_CAP_RISE4) || (m == CCU_CAP_RISE16);
	endfunction

	function automatic logic is_compare(input logic [3:0] m);
		is_compare = (m == CCU_CMP_TOGGLE) || (m == CCU_CMP_SET) || (m == CCU_CMP_CLEAR) ||
			(m == CCU_CMP_SWINT) || (m == CCU_CMP_SPECIAL);
	endfunction

	function automatic logic drives_pin(input logic [3:0] m);
		drives_pin = (m == CCU_CMP_TOGGLE) || (m == CCU_CMP_SET) || (m == CCU_CMP_CLEAR);
	endfunction

	logic [7:0] ctrl_q;
	logic [15:0] value_q;
	logic flag_q;
	logic ien_q;
	logic alt_sel_q;
	logic [`CCU_PS_W-1:0] ps_cnt_q;
	logic [1:0] pin_a_sync_q;
	logic [1:0] pin_b_sync_q;
	logic cap_prev_q;
	logic match_q;
	logic out_latch_q;
	logic clear_pend_q;
	logic [7:0] rdata_q;

	logic [3:0] mode;
	logic cap_now;
	logic cap_rise;
	logic cap_fall;
	logic cap_event;
	logic match;
	logic cmp_hit;
	logic wr_ctrl;
	logic wr_val_lo;
	logic wr_val_hi;
	logic wr_flags;
	logic wr_alt;
	logic use_b;

	assign mode = ctrl_q[`CCU_MODE_HI:`CCU_MODE_LO];
	assign wr_ctrl = LINK.reg_wr && (LINK.reg_addr == `CCU_ADDR_CTRL);
	assign wr_val_lo = LINK.reg_wr && (LINK.reg_addr == `CCU_ADDR_VAL_LO);
	assign wr_val_hi = LINK.reg_wr && (LINK.reg_addr == `CCU_ADDR_VAL_HI);
	assign wr_flags = LINK.reg_wr && (LINK.reg_addr == `CCU_ADDR_FLAGS);
	assign wr_alt = LINK.reg_wr && (LINK.reg_addr == `CCU_ADDR_ALT);
	assign use_b = IS_UNIT_TWO && alt_sel_q;

	// Only the second flip-flop of each synchroniser feeds the edge logic.
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			pin_a_sync_q <= 2'h0;
			pin_b_sync_q <= 2'h0;
		end else begin
			pin_a_sync_q <= {pin_a_sync_q[0], PIN_A_I};
			pin_b_sync_q <= {pin_b_sync_q[0], PIN_B_I};
		end
	end

	assign cap_now = use_b ? pin_b_sync_q[1] : pin_a_sync_q[1];
	assign cap_rise = cap_now && !cap_prev_q;
	assign cap_fall = !cap_now && cap_prev_q;

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			cap_prev_q <= 1'b0;
		end else begin
			cap_prev_q <= cap_now;
		end
	end

	// A change between two capture modes leaves the count alone, so the new
	// divider may fire early; software avoids this by switching off first.
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			ps_cnt_q <= `CCU_PS_RST;
		end else if (!is_capture(mode)) begin
			ps_cnt_q <= `CCU_PS_RST;
		end else if (cap_rise) begin
			ps_cnt_q <= ps_cnt_q + `CCU_PS_W'(1);
		end
	end

	always_comb begin
		unique case (mode)
			CCU_CAP_FALL: cap_event = cap_fall;
			CCU_CAP_RISE: cap_event = cap_rise;
			CCU_CAP_RISE4: cap_event = cap_rise && (ps_cnt_q[1:0] == `CCU_PS_FOURTH);
			CCU_CAP_RISE16: cap_event = cap_rise && (ps_cnt_q == `CCU_PS_SIXTEENTH);
			default: cap_event = 1'b0;
		endcase
	end

	assign match = is_compare(mode) && (LINK.timer_count == value_q);
	assign cmp_hit = match && !match_q;

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			match_q <= 1'b0;
		end else begin
			match_q <= match;
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			ctrl_q <= `CCU_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= LINK.reg_wdata & `CCU_CTRL_MASK;
		end
	end

	// The timer is sampled on the event cycle; a later capture simply
	// replaces an unread one, and capture beats a software write.
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			value_q <= `CCU_TMR_RST;
		end else if (cap_event) begin
			value_q <= LINK.timer_count;
		end else if (wr_val_lo) begin
			value_q[7:0] <= LINK.reg_wdata;
		end else if (wr_val_hi) begin
			value_q[15:8] <= LINK.reg_wdata;
		end
	end

	// A hardware set in the same cycle as a software clear wins.
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			flag_q <= 1'b0;
			ien_q <= 1'b0;
		end else begin
			if (cap_event || cmp_hit) begin
				flag_q <= 1'b1;
			end else if (wr_flags) begin
				flag_q <= LINK.reg_wdata[`CCU_FLAG_BIT];
			end
			if (wr_flags) begin
				ien_q <= LINK.reg_wdata[`CCU_IEN_BIT];
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			alt_sel_q <= 1'b0;
		end else if (wr_alt) begin
			alt_sel_q <= LINK.reg_wdata[`CCU_ALT_SEL_BIT];
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			out_latch_q <= 1'b0;
		end else if (wr_ctrl && (LINK.reg_wdata == `CCU_CTRL_RST)) begin
			out_latch_q <= 1'b0;
		end else if (cmp_hit) begin
			unique case (mode)
				CCU_CMP_TOGGLE: out_latch_q <= !out_latch_q;
				CCU_CMP_SET: out_latch_q <= 1'b1;
				CCU_CMP_CLEAR: out_latch_q <= 1'b0;
				default: out_latch_q <= out_latch_q;
			endcase
		end
	end

	// The clear waits for the next timer tick, and is dropped if the match
	// goes away before then, so a moved period value cancels it.
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			clear_pend_q <= 1'b0;
		end else if (cmp_hit && (mode == CCU_CMP_SPECIAL)) begin
			clear_pend_q <= 1'b1;
		end else if (LINK.timer_tick || !match) begin
			clear_pend_q <= 1'b0;
		end
	end

	assign LINK.timer_clear_req = clear_pend_q;

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			ADC_START_O <= 1'b0;
		end else begin
			ADC_START_O <= IS_UNIT_TWO && cmp_hit && (mode == CCU_CMP_SPECIAL);
		end
	end

	// Pin drive only in the three pin modes; software interrupt and special
	// event modes leave the pin to the port.
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			PIN_A_O <= 1'b0;
			PIN_A_OE_O <= 1'b0;
			PIN_B_O <= 1'b0;
			PIN_B_OE_O <= 1'b0;
		end else begin
			PIN_A_O <= out_latch_q && !use_b;
			PIN_A_OE_O <= drives_pin(mode) && DIR_OUT_I && !use_b;
			PIN_B_O <= out_latch_q && use_b;
			PIN_B_OE_O <= drives_pin(mode) && DIR_OUT_I && use_b;
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			IRQ_FLAG_O <= 1'b0;
			IRQ_O <= 1'b0;
		end else begin
			IRQ_FLAG_O <= flag_q;
			IRQ_O <= flag_q && ien_q;
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rdata_q <= 8'h00;
		end else begin
			unique case (LINK.reg_addr)
				`CCU_ADDR_CTRL: rdata_q <= ctrl_q;
				`CCU_ADDR_VAL_LO: rdata_q <= value_q[7:0];
				`CCU_ADDR_VAL_HI: rdata_q <= value_q[15:8];
				`CCU_ADDR_FLAGS: rdata_q <= {6'h00, ien_q, flag_q};
				`CCU_ADDR_ALT: rdata_q <= {7'h00, alt_sel_q && IS_UNIT_TWO};
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	assign LINK.reg_rdata = rdata_q;

endmodule

// file: ccu_defines.svh
// Purpose: Shared offsets, field positions, reset values and counts for the compare unit.
// Assumes: Included by bare name from every file that needs a constant.
// Notes: Register addresses are word indexes on a small byte-wide register port.
`ifndef CCU_DEFINES_SVH
`define CCU_DEFINES_SVH

`define CCU_ADDR_W 3
`define CCU_ADDR_CTRL 3'h0
`define CCU_ADDR_VAL_LO 3'h1
`define CCU_ADDR_VAL_HI 3'h2
`define CCU_ADDR_FLAGS 3'h3
`define CCU_ADDR_ALT 3'h4
`define CCU_ADDR_TMR_LO 3'h5
`define CCU_ADDR_TMR_HI 3'h6

`define CCU_CTRL_RST 8'h00
`define CCU_CTRL_MASK 8'h3f
`define CCU_MODE_HI 3
`define CCU_MODE_LO 0
`define CCU_FLAG_BIT 0
`define CCU_IEN_BIT 1
`define CCU_ALT_SEL_BIT 0

`define CCU_PS_W 4
`define CCU_PS_RST 4'h0
`define CCU_PS_FOURTH 2'h3
`define CCU_PS_SIXTEENTH 4'hf

`define CCU_TMR_RST 16'h0000
`define CCU_TMR_MAX 16'hffff
`define CCU_TMR_ONE 16'h0001
`define CCU_INSTR_DIV 2'h3

`endif

// file: ccu_pkg.sv
// Purpose: Types shared by both ends of the compare unit link.
// Assumes: Mode codes are those of the unit mode field.
// Notes: Codes not listed are reserved and behave as unit off.
package ccu_pkg;

	typedef enum logic [3:0] {
		CCU_OFF = 4'h0,
		CCU_CMP_TOGGLE = 4'h2,
		CCU_CAP_FALL = 4'h4,
		CCU_CAP_RISE = 4'h5,
		CCU_CAP_RISE4 = 4'h6,
		CCU_CAP_RISE16 = 4'h7,
		CCU_CMP_SET = 4'h8,
		CCU_CMP_CLEAR = 4'h9,
		CCU_CMP_SWINT = 4'ha,
		CCU_CMP_SPECIAL = 4'hb
	} ccu_mode_t;

endpackage

// file: ccu_link_if.sv
// Purpose: Link between the timer and software side and one compare unit.
// Assumes: Both ends run on the same clock.
// Notes: The device end answers register reads one cycle after the address.
`timescale 1ns/1ns
`include "ccu_defines.svh"

interface ccu_link_if;
	logic reg_wr;
	logic [`CCU_ADDR_W-1:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [15:0] timer_count;
	logic timer_tick;
	logic timer_clear_req;

	modport dev (
		input reg_wr,
		input reg_addr,
		input reg_wdata,
		output reg_rdata,
		input timer_count,
		input timer_tick,
		output timer_clear_req
	);

	modport host (
		output reg_wr,
		output reg_addr,
		output reg_wdata,
		input reg_rdata,
		output timer_count,
		output timer_tick,
		input timer_clear_req
	);
endinterface

// file: ccu_timer_host.sv
// Purpose: Far end of the compare unit: 16-bit timer and software register port.
// Assumes: The external timer clock is slow against CLK_I.
// Notes: Writes to unit addresses are forwarded one cycle later.
`timescale 1ns/1ns
`include "ccu_defines.svh"

module ccu_timer_host
	import ccu_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	ccu_link_if.host LINK,
	input wire logic SW_WR_I,
	input wire logic [`CCU_ADDR_W-1:0] SW_ADDR_I,
	input wire logic [7:0] SW_WDATA_I,
	output logic [7:0] SW_RDATA_O,
	input wire logic TMR_ON_I,
	input wire logic CLK_SRC_EXT_I,
	input wire logic EXT_CLK_I,
	input wire logic SLEEP_I,
	input wire logic OVF_CLR_I,
	output logic TIMER_OVF_O
);

	logic [15:0] count_q;
	logic tick_q;
	logic [1:0] div_q;
	logic [1:0] ext_sync_q;
	logic ext_prev_q;
	logic wr_q;
	logic [`CCU_ADDR_W-1:0] addr_q;
	logic [7:0] wdata_q;
	logic tick_d;

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			ext_sync_q <= 2'h0;
			ext_prev_q <= 1'b0;
		end else begin
			ext_sync_q <= {ext_sync_q[0], EXT_CLK_I};
			ext_prev_q <= ext_sync_q[1];
		end
	end

	// The instruction-clock divider stops in sleep, so the count simply
	// resumes afterwards; an external clock keeps ticking through sleep.
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			div_q <= 2'h0;
		end else if (!SLEEP_I) begin
			div_q <= div_q + 2'h1;
		end
	end

	always_comb begin
		if (!TMR_ON_I) begin
			tick_d = 1'b0;
		end else if (CLK_SRC_EXT_I) begin
			tick_d = ext_sync_q[1] && !ext_prev_q;
		end else begin
			tick_d = !SLEEP_I && (div_q == `CCU_INSTR_DIV);
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= tick_d;
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			count_q <= `CCU_TMR_RST;
		end else if (SW_WR_I && (SW_ADDR_I == `CCU_ADDR_TMR_LO)) begin
			count_q[7:0] <= SW_WDATA_I;
		end else if (SW_WR_I && (SW_ADDR_I == `CCU_ADDR_TMR_HI)) begin
			count_q[15:8] <= SW_WDATA_I;
		end else if (tick_q && LINK.timer_clear_req) begin
			count_q <= `CCU_TMR_RST;
		end else if (tick_q) begin
			count_q <= count_q + `CCU_TMR_ONE;
		end
	end

	// Set wins over a clear in the same cycle; the trigger clear never sets it.
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			TIMER_OVF_O <= 1'b0;
		end else if (tick_q && !LINK.timer_clear_req && (count_q == `CCU_TMR_MAX)) begin
			TIMER_OVF_O <= 1'b1;
		end else if (OVF_CLR_I) begin
			TIMER_OVF_O <= 1'b0;
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			wr_q <= 1'b0;
			addr_q <= `CCU_ADDR_CTRL;
			wdata_q <= 8'h00;
		end else begin
			wr_q <= SW_WR_I && (SW_ADDR_I <= `CCU_ADDR_ALT);
			addr_q <= SW_ADDR_I;
			wdata_q <= SW_WDATA_I;
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			SW_RDATA_O <= 8'h00;
		end else if (addr_q == `CCU_ADDR_TMR_LO) begin
			SW_RDATA_O <= count_q[7:0];
		end else if (addr_q == `CCU_ADDR_TMR_HI) begin
			SW_RDATA_O <= count_q[15:8];
		end else begin
			SW_RDATA_O <= LINK.reg_rdata;
		end
	end

	assign LINK.reg_wr = wr_q;
	assign LINK.reg_addr = addr_q;
	assign LINK.reg_wdata = wdata_q;
	assign LINK.timer_count = count_q;
	assign LINK.timer_tick = tick_q;

endmodule

// file: ccu_link_asserts.sv
// Purpose: Link checks between the timer host and one compare unit.
// Assumes: One clock; reset is asynchronous and active low.
// Notes: Mode and value shadows are rebuilt from writes seen on the link.
`timescale 1ns/1ns
`include "ccu_defines.svh"
module ccu_link_asserts
	import ccu_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	input wire logic reg_wr,
	input wire logic [`CCU_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [15:0] timer_count,
	input wire logic timer_tick,
	input wire logic timer_clear_req
);
	logic [3:0] mode_q;
	logic [15:0] val_q;
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (!RESET_N_I);
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			mode_q <= 4'h0;
		end else if (reg_wr && reg_addr == `CCU_ADDR_CTRL) begin
			mode_q <= reg_wdata[3:0];
		end
	end
	// Captures also load the value, so it is trusted only outside capture modes.
	always_ff @(posedge CLK_I) begin
		if (reg_wr && reg_addr == `CCU_ADDR_VAL_LO) begin
			val_q[7:0] <= reg_wdata;
		end
		if (reg_wr && reg_addr == `CCU_ADDR_VAL_HI) begin
			val_q[15:8] <= reg_wdata;
		end
	end
	sequence s_wr(a);
		reg_wr && reg_addr == a;
	endsequence
	sequence s_hold(a);
		!reg_wr && reg_addr == a;
	endsequence
	a_ctrl_readback: assert property (
		s_wr(`CCU_ADDR_CTRL) ##1 s_hold(`CCU_ADDR_CTRL)
		|=> reg_rdata == ($past(reg_wdata, 2) & 8'h3f))
		else $error("control readback wrong");
	a_value_readback: assert property (
		(mode_q[3:2] != 2'b01) ##0 s_wr(`CCU_ADDR_VAL_LO) ##1 s_hold(`CCU_ADDR_VAL_LO)
		|=> reg_rdata == $past(reg_wdata, 2))
		else $error("value readback wrong");
	a_addr_seven: assert property (
		reg_addr == 3'h7 |=> reg_rdata == 8'h00)
		else $error("unused address not zero");
	a_clear_mode: assert property (
		timer_clear_req |-> mode_q == CCU_CMP_SPECIAL || $past(mode_q) == CCU_CMP_SPECIAL)
		else $error("timer clear outside special mode");
	a_clear_hit: assert property (
		$rose(timer_clear_req) |-> $past(timer_count) == $past(val_q))
		else $error("timer clear without match");
	a_clear_drops: assert property (
		timer_clear_req && timer_tick |-> ##[1:2] !timer_clear_req)
		else $error("timer clear held past tick");
	a_timer_zero: assert property (
		timer_clear_req && timer_tick |-> ##[1:2] timer_count == 16'h0000)
		else $error("timer not cleared");
	a_tick_pulse: assert property (
		timer_tick |=> !timer_tick)
		else $error("tick longer than one cycle");
endmodule

// file: capture_prescale_and_compare_unit_tb_top.sv
// Purpose: Self-checking bench joining the timer host and compare unit two.
// Assumes: Pin B input stays idle; the alternate select is set once to check the pin outputs.
// Notes: The timer is stopped before each readback so counts are exact.
`timescale 1ns/1ns
`include "ccu_defines.svh"
module capture_prescale_and_compare_unit_tb_top
	import ccu_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sw_wr = 1'b0;
	logic [2:0] sw_addr = 3'h0;
	logic [7:0] sw_wdata = 8'h00;
	logic [7:0] sw_rdata;
	logic tmr_on = 1'b0;
	logic src_ext = 1'b0;
	logic ext_clk = 1'b0;
	logic slp = 1'b0;
	logic pin_a = 1'b0;
	logic dir_out = 1'b1;
	logic ovf, pa_o, pa_oe, pb_o, pb_oe, flag, irq, adc;
	logic [15:0] lf = 16'h6a4f;
	logic [15:0] capq [$];
	// The last two entries run to the top count: a special clear, then a plain roll-over.
	logic [3:0] cm [8] = '{4'h8, 4'h9, 4'h2, 4'ha, 4'hb, 4'h2, 4'hb, 4'h8};
	logic [3:0] cap [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
	int cn [4] = '{1, 1, 4, 16};
	int err_count = 0;
	int checked = 0;
	int cyc = 0;
	ccu_link_if link ();
	ccu_timer_host ccu_timer_host_inst (.CLK_I(clk), .RESET_N_I(rst_n), .LINK(link.host),
		.SW_WR_I(sw_wr), .SW_ADDR_I(sw_addr), .SW_WDATA_I(sw_wdata), .SW_RDATA_O(sw_rdata),
		.TMR_ON_I(tmr_on), .CLK_SRC_EXT_I(src_ext), .EXT_CLK_I(ext_clk), .SLEEP_I(slp),
		.OVF_CLR_I(1'b0), .TIMER_OVF_O(ovf));
	ccu_unit #(.UNIT_ID(2)) ccu_unit_inst (.CLK_I(clk), .RESET_N_I(rst_n), .LINK(link.dev),
		.PIN_A_I(pin_a), .PIN_B_I(1'b0), .DIR_OUT_I(dir_out), .PIN_A_O(pa_o),
		.PIN_A_OE_O(pa_oe), .PIN_B_O(pb_o), .PIN_B_OE_O(pb_oe), .IRQ_FLAG_O(flag), .IRQ_O(irq),
		.ADC_START_O(adc));
	ccu_link_asserts ccu_link_asserts_inst (.CLK_I(clk), .RESET_N_I(rst_n),
		.reg_wr(link.reg_wr), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
		.reg_rdata(link.reg_rdata), .timer_count(link.timer_count),
		.timer_tick(link.timer_tick), .timer_clear_req(link.timer_clear_req));
	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			end_sim();
		end
	end
	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		sw_wr <= 1'b1;
		sw_addr <= a;
		sw_wdata <= d;
		@(posedge clk);
		sw_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		sw_addr <= a;
		repeat (4) @(posedge clk);
		#1 d = sw_rdata;
	endtask
	task automatic setup(input logic [15:0] v, input logic [3:0] m, input logic en);
		wr(`CCU_ADDR_TMR_LO, v[7:0] - 8'h03);
		wr(`CCU_ADDR_TMR_HI, v[15:8]);
		wr(`CCU_ADDR_VAL_LO, v[7:0]);
		wr(`CCU_ADDR_VAL_HI, v[15:8]);
		wr(`CCU_ADDR_CTRL, {4'h0, m});
		wr(`CCU_ADDR_FLAGS, {6'h00, en, 1'b0});
	endtask
	// The start pulse lasts one cycle, so it is watched on every cycle of the wait after the first four.
	task automatic wflag(output logic a);
		a = 1'b0;
		repeat (4) @(posedge clk);
		repeat (60) begin
			@(posedge clk);
			#1;
			if (adc === 1'b1) begin
				a = 1'b1;
			end
			if (flag === 1'b1) begin
				break;
			end
		end
	endtask
	task automatic pulse(input int n, input logic ext);
		repeat (n) begin
			repeat (4) @(posedge clk);
			pin_a <= !ext;
			ext_clk <= ext;
			repeat (4) @(posedge clk);
			pin_a <= 1'b0;
			ext_clk <= 1'b0;
		end
		repeat (8) @(posedge clk);
		#1;
	endtask
	task automatic end_sim();
		$display("counts: %0d checks, %0d mismatches", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		logic [7:0] d;
		logic [7:0] h;
		logic [15:0] v;
		logic a;
		logic oe;
		int latch;
		latch = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rd(`CCU_ADDR_CTRL, d);
		chk(d, 8'h00);
		rd(`CCU_ADDR_FLAGS, d);
		chk(d, 8'h00);
		wr(`CCU_ADDR_CTRL, 8'hff);
		rd(`CCU_ADDR_CTRL, d);
		chk(d, 8'h3f);
		rd(3'h7, d);
		chk(d, 8'h00);
		$display("test registers done");
		foreach (cm[i]) begin
			if (i == 5) begin
				wr(`CCU_ADDR_CTRL, 8'h00);
				latch = 0;
			end
			lf = nxt(lf);
			v = (i >= 6) ? 16'hffff : {lf[7:0] | 8'h10, 8'h40};
			setup(v, cm[i], i != 3);
			tmr_on <= 1'b1;
			wflag(a);
			chk(flag, 1'b1);
			chk(irq, i != 3);
			chk(a, cm[i] == 4'hb);
			repeat (8) @(posedge clk);
			tmr_on <= 1'b0;
			#1;
			case (cm[i])
				4'h8: latch = 1;
				4'h9: latch = 0;
				4'h2: latch = 1 - latch;
				default: latch = latch;
			endcase
			oe = cm[i] == 4'h2 || cm[i] == 4'h8 || cm[i] == 4'h9;
			chk(pa_oe, oe);
			if (oe) begin
				chk(pa_o, latch[0]);
			end
			chk(ovf, cm[i] != 4'hb && v == 16'hffff);
			rd(`CCU_ADDR_TMR_HI, d);
			chk(d, (cm[i] == 4'hb || v == 16'hffff) ? 8'h00 : v[15:8]);
		end
		wr(`CCU_ADDR_ALT, 8'h01);
		rd(`CCU_ADDR_ALT, d);
		chk(d, 8'h01);
		chk(pb_oe, 1'b1);
		chk(pb_o, latch[0]);
		chk(pa_oe, 1'b0);
		@(posedge clk);
		dir_out <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk(pb_oe, 1'b0);
		@(posedge clk);
		dir_out <= 1'b1;
		wr(`CCU_ADDR_ALT, 8'h00);
		$display("test compare done");
		// Each capture sees a fresh timer value, so only the newest one may survive.
		foreach (cap[i]) begin
			lf = nxt(lf);
			wr(`CCU_ADDR_TMR_LO, lf[7:0]);
			wr(`CCU_ADDR_TMR_HI, lf[15:8]);
			capq.push_back(lf);
			wr(`CCU_ADDR_CTRL, 8'h00);
			wr(`CCU_ADDR_FLAGS, 8'h02);
			wr(`CCU_ADDR_CTRL, {4'h0, cap[i]});
			pulse(cn[i] - 1, 1'b0);
			chk(flag, 1'b0);
			pulse(1, 1'b0);
			chk(flag, 1'b1);
		end
		rd(`CCU_ADDR_VAL_LO, d);
		rd(`CCU_ADDR_VAL_HI, h);
		chk({h, d}, capq[$]);
		wr(`CCU_ADDR_CTRL, 8'h00);
		wr(`CCU_ADDR_FLAGS, 8'h02);
		wr(`CCU_ADDR_CTRL, 8'h07);
		pulse(3, 1'b0);
		chk(flag, 1'b0);
		wr(`CCU_ADDR_CTRL, 8'h06);
		pulse(1, 1'b0);
		chk(flag, 1'b1);
		$display("test capture done");
		wr(`CCU_ADDR_TMR_LO, 8'h00);
		wr(`CCU_ADDR_TMR_HI, 8'h00);
		slp <= 1'b1;
		tmr_on <= 1'b1;
		repeat (40) @(posedge clk);
		rd(`CCU_ADDR_TMR_LO, d);
		chk(d, 8'h00);
		// Forty awake cycles give exactly ten internal ticks, whatever the divider phase.
		@(posedge clk);
		slp <= 1'b0;
		repeat (40) @(posedge clk);
		slp <= 1'b1;
		rd(`CCU_ADDR_TMR_LO, d);
		chk(d, 8'h0a);
		src_ext <= 1'b1;
		pulse(4, 1'b1);
		tmr_on <= 1'b0;
		rd(`CCU_ADDR_TMR_LO, d);
		chk(d, 8'h0e);
		wr(`CCU_ADDR_CTRL, 8'h00);
		wr(`CCU_ADDR_FLAGS, 8'h02);
		wr(`CCU_ADDR_CTRL, 8'h05);
		pulse(1, 1'b0);
		chk(flag, 1'b1);
		rd(`CCU_ADDR_VAL_LO, d);
		chk(d, 8'h0e);
		$display("test sleep done");
		end_sim();
	end
endmodule
